//--- attach_chk.sv
// Port checker for the attach controller, bound to its top module.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module attach_chk #(
    parameter int SETTLE_CYC = 20,
    parameter int DEBOUNCE_CYC = 4
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cable_reset,
    input wire logic i_online_switch,
    input wire logic i_grant_in,
    input wire logic i_lock_in,
    input wire logic o_grant_out,
    input wire logic o_lock_oe,
    input wire logic o_relay_close,
    input wire logic o_abort,
    input wire logic o_lines_release,
    input wire logic [1:0] o_attach_state,
    input wire attach_pkg::perm_s o_perm
);
    int lock_ff;
    int age_ff;
    int low_ff;
    logic relay_ff;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_ff <= 0;
            age_ff <= 0;
            low_ff <= 0;
            relay_ff <= 1'b0;
        end else begin
            lock_ff <= o_lock_oe ? lock_ff + 1 : 0;
            age_ff <= (o_relay_close != relay_ff) ? 0 : age_ff + 1;
            low_ff <= i_online_switch ? 0 : low_ff + 1;
            relay_ff <= o_relay_close;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    AST_STATE_LEGAL: assert property (o_attach_state != 2'b11)
        else $error("illegal attach state");
    AST_OFF_GRANT: assert property (o_attach_state == 2'b00 |-> o_grant_out == i_grant_in)
        else $error("grant chain broken while offline");
    AST_OFF_QUIET: assert property (o_attach_state == 2'b00 |-> o_perm == 7'h00)
        else $error("offline device has bus roles");
    AST_DIS_PERM: assert property (o_attach_state == 2'b01 && !o_abort && !o_lines_release
        |-> o_perm == {3'b101, !(i_lock_in || o_lock_oe), 3'b001})
        else $error("wrong roles while disabled");
    AST_EN_PERM: assert property (o_attach_state == 2'b10 && !o_abort && !o_lines_release
        |-> o_perm == {3'b111, !(i_lock_in || o_lock_oe), 3'b111})
        else $error("wrong roles while enabled");
    AST_RELAY_LATE: assert property ($changed(o_relay_close)
        |-> o_lock_oe && lock_ff >= attach_pkg::RELAY_DELAY_CYC - 2)
        else $error("relay moved too early");
    AST_SETTLE: assert property ($fell(o_lock_oe) |-> age_ff >= SETTLE_CYC - 2)
        else $error("lock released before relay settled");
    AST_LOCK_MIN: assert property ($fell(o_lock_oe) |-> lock_ff >= attach_pkg::LOCK_SHORT_CYC - 1)
        else $error("lock pulse too short");
    AST_GRESET: assert property ($rose(i_cable_reset) |-> ##[1:4] o_abort)
        else $error("no abort on global reset");
    AST_GRESET_ST: assert property (i_cable_reset [*6] |-> o_attach_state != 2'b10)
        else $error("enabled during global reset");
    AST_SWITCH: assert property (low_ff >= DEBOUNCE_CYC + 8 |-> o_attach_state == 2'b00)
        else $error("switch offline not obeyed");
endmodule // attach_chk

bind cable_bus_reset_and_attach_state attach_chk #(.SETTLE_CYC(SETTLE_CYC),
    .DEBOUNCE_CYC(DEBOUNCE_CYC)) i_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cable_reset(i_cable_reset), .i_online_switch(i_online_switch), .i_grant_in(i_grant_in),
    .i_lock_in(i_lock_in),
    .o_grant_out(o_grant_out), .o_lock_oe(o_lock_oe), .o_relay_close(o_relay_close),
    .o_abort(o_abort), .o_lines_release(o_lines_release), .o_attach_state(o_attach_state),
    .o_perm(o_perm));

//--- attach_pkg.sv
// Constants, types and field layouts for the cable bus reset and attach controller.
// Assumes a single 125 MHz clock and an Avalon-MM register master.
// Functional notes
// R1: Watch the global cable reset line continuously and react to it.
// R2: The driver of global reset holds it at least 200 ms. The cable_peer model holds it for HOLD_CYC = 40 cycles only.
// R3: Global reset releases all lines at once and enters online-disabled.
// R4: Writing 1 to the control reset bit or own reset-register bit resets selectively.
// R5: Selective reset waits until the carrying write completes, then resets.
// R6: Selective reset is also accepted from a broadcast write.
// R7: Exactly one of offline, online-disabled, online-enabled is held.
// R8: Offline means no response to and no driving of any bus activity. The code still drives the lock line while offline during relay switching.
// R9: Offline passes incoming grant straight to outgoing grant.
// R10: Front-panel switch at offline forces offline over everything else.
// R11: Writing 0 to remote attach bit goes offline; writing 1 does nothing.
// R12: After remote offline, only a local request returns online, switch online; global reset and selective reset also enter online-disabled here.
// R13: Online-disabled slave ignores transparent cycles; direct cycles stay allowed.
// R14: Online-disabled interface forwards no backplane interrupts nor answers their acknowledges.
// R15: Online-disabled may master cycles, forward cycles, request and handle interrupts.
// R16: Online-enabled permits all functions, only with a backplane present.
// R17: Power-up state may be any of three; enabled only with backplane.
// R18: Assert arbitration lock first; switch relays no sooner than 1.2 us later.
// R19: Hold arbitration lock until relay contacts settle, then release.
// R20: Under arbitration lock, requesters ignore the grant chain and keep waiting.
// R21: Every arbitration lock assertion lasts at least two cable propagation times.
// R22: Keep driving select clocks while removing, before releasing arbitration lock. The code has no select clock output.
// R23: Minimum lock time is 1.2 us long cable, 0.36 us short cable.
// R24: Synchronise and debounce the front-panel switch before use.
package attach_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RELAY_DELAY_NS = 1200;
    localparam int LOCK_LONG_NS = 1200;
    localparam int LOCK_SHORT_NS = 360;
    localparam int RELAY_DELAY_CYC = (RELAY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_LONG_CYC = (LOCK_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_SHORT_CYC = (LOCK_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_US = 1000;
    localparam int SETTLE_CYC_DEF = SETTLE_US * 125;
    localparam int DEBOUNCE_US = 1000;
    localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_US * 125;
    localparam int CNT_W = 20;

    // ------------------------------------------------------------
    // Register map (byte addresses, word index in address bits 3:2)
    // ------------------------------------------------------------
    localparam logic [3:0] CSR_OFS = 4'h0;
    localparam logic [3:0] RR_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] CFG_OFS = 4'hC;
    localparam int CSR_RESET_BIT = 0;
    localparam int CSR_ONLINE_BIT = 1;
    localparam int CSR_TRANSP_BIT = 2;
    localparam int CSR_CABLEL_BIT = 3;
    localparam int CFG_LOCAL_ON_BIT = 0;
    localparam int CFG_LOCAL_OFF_BIT = 1;
    localparam int CFG_LOCK_REQ_BIT = 2;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFFLINE = 2'b00,
        ST_DISABLED = 2'b01,
        ST_ENABLED = 2'b10
    } attach_e;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_PRE = 2'b01,
        LK_SETTLE = 2'b10
    } lock_e;

    localparam attach_e POWERUP_STATE = ST_DISABLED;

    typedef struct packed {
        logic slave_direct;
        logic slave_transp;
        logic master;
        logic requester;
        logic intr_fwd;
        logic iack_fwd;
        logic intr_handler;
    } perm_s;

    typedef struct packed {
        attach_e attach;
        logic remote_off;
        logic sreset_pend;
        lock_e lock;
        logic [CNT_W-1:0] lock_cnt;
        logic relay_closed;
        logic [2:0] sw_sync;
        logic sw_stable;
        logic [CNT_W-1:0] db_cnt;
        logic [2:0] rst_sync;
        logic transp;
        logic cablel;
        logic [31:0] rdata;
        logic rvalid;
    } state_s;

endpackage

//--- cable_bus_reset_and_attach_state.sv
// Reset, attachment state and hot-connection sequencer for one cable bus device.
// Assumes cable pins are already converted to single-ended logic outside.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module cable_bus_reset_and_attach_state #(
    parameter int SETTLE_CYC = attach_pkg::SETTLE_CYC_DEF,
    parameter int DEBOUNCE_CYC = attach_pkg::DEBOUNCE_CYC_DEF,
    parameter logic [4:0] DEVICE_NUMBER = 5'h01,
    parameter bit HAS_BACKPLANE = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_cable_reset,
    input wire logic i_online_switch,
    input wire logic i_grant_in,
    output logic o_grant_out,
    input wire logic i_grant_local,
    input wire logic i_cycle_done,
    output logic o_lock_out,
    output logic o_lock_oe,
    input wire logic i_lock_in,
    output logic o_relay_close,
    output logic o_abort,
    output logic o_lines_release,
    output logic o_remove_ok,
    output logic [1:0] o_attach_state,
    output attach_pkg::perm_s o_perm
);

    localparam int CNT_W_L = attach_pkg::CNT_W;

    attach_pkg::state_s cur_ff;
    attach_pkg::state_s nxt_ff;
    logic sw_online;
    logic gl_rst;
    logic cs_acc;
    logic wr_csr;
    logic wr_rr;
    logic wr_cfg;
    logic lock_min_done;
    logic go_online;
    logic [CNT_W_L-1:0] lock_min;

    // ------------------------------------------------------------
    // Combinational view of the state
    // ------------------------------------------------------------
    assign sw_online = cur_ff.sw_stable;
    assign gl_rst = cur_ff.rst_sync[2] & cur_ff.rst_sync[1];  // [R1]
    assign cs_acc = (i_avs_read | i_avs_write) & ~cur_ff.rvalid;
    // Writes take effect at the edge that acknowledges them, with waitrequest low.
    assign wr_csr = i_avs_write & cur_ff.rvalid & (i_avs_address == attach_pkg::CSR_OFS)
        & i_avs_byteenable[0];
    assign wr_rr = i_avs_write & cur_ff.rvalid & (i_avs_address == attach_pkg::RR_OFS);
    assign wr_cfg = i_avs_write & cur_ff.rvalid & (i_avs_address == attach_pkg::CFG_OFS)
        & i_avs_byteenable[0];
    assign lock_min = cur_ff.cablel ? CNT_W_L'(attach_pkg::LOCK_LONG_CYC)
        : CNT_W_L'(attach_pkg::LOCK_SHORT_CYC);  // [R23]
    assign lock_min_done = cur_ff.lock_cnt >= CNT_W_L'(attach_pkg::RELAY_DELAY_CYC)
        && cur_ff.lock_cnt >= lock_min;  // [R18] [R21]
    assign go_online = wr_cfg & i_avs_writedata[attach_pkg::CFG_LOCAL_ON_BIT];

    function automatic logic rr_hit(input logic [31:0] d, input logic [4:0] n);
        rr_hit = d[n];
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rvalid = 1'b0;
        nxt_ff.rst_sync = {cur_ff.rst_sync[1:0], i_cable_reset};
        nxt_ff.sw_sync = {cur_ff.sw_sync[1:0], i_online_switch};
        // Switch debounce: a change counts once held stable for the full window.
        if ((cur_ff.sw_sync[2] == cur_ff.sw_sync[1]) && (cur_ff.sw_sync[1] != cur_ff.sw_stable)) begin
            if (cur_ff.db_cnt >= CNT_W_L'(DEBOUNCE_CYC)) begin
                nxt_ff.sw_stable = cur_ff.sw_sync[1];  // [R24]
                nxt_ff.db_cnt = '0;
            end else begin
                nxt_ff.db_cnt = cur_ff.db_cnt + CNT_W_L'(1);
            end
        end else begin
            nxt_ff.db_cnt = '0;
        end
        // Register access.
        if (cs_acc && i_avs_read) begin
            nxt_ff.rvalid = 1'b1;
            unique case (i_avs_address)
                attach_pkg::CSR_OFS: nxt_ff.rdata = {28'h0000000, cur_ff.cablel, cur_ff.transp,
                    cur_ff.attach != attach_pkg::ST_OFFLINE, 1'b0};
                attach_pkg::STAT_OFS: nxt_ff.rdata = {24'h000000, cur_ff.relay_closed,
                    cur_ff.lock, cur_ff.remote_off, sw_online, cur_ff.sreset_pend,
                    cur_ff.attach};
                default: nxt_ff.rdata = attach_pkg::UNMAPPED_RD;
            endcase
        end else if (cs_acc && i_avs_write) begin
            nxt_ff.rvalid = 1'b1;
        end
        if (wr_csr) begin
            nxt_ff.transp = i_avs_writedata[attach_pkg::CSR_TRANSP_BIT];
            nxt_ff.cablel = i_avs_writedata[attach_pkg::CSR_CABLEL_BIT];
        end
        // Attachment state: one encoded value, so exactly one state holds.
        if (cur_ff.sreset_pend && i_cycle_done) begin
            nxt_ff.sreset_pend = 1'b0;
            nxt_ff.transp = 1'b0;
            nxt_ff.attach = attach_pkg::ST_DISABLED;  // [R5] [R7]
        end
        // Selective reset, from own or broadcast write alike; a new request wins the clear.
        if ((wr_csr && i_avs_writedata[attach_pkg::CSR_RESET_BIT])
            || (wr_rr && rr_hit(i_avs_writedata, DEVICE_NUMBER))) begin
            nxt_ff.sreset_pend = 1'b1;  // [R4] [R6]
        end
        if (wr_csr && !i_avs_writedata[attach_pkg::CSR_ONLINE_BIT]) begin
            nxt_ff.attach = attach_pkg::ST_OFFLINE;  // [R11]
            nxt_ff.remote_off = 1'b1;
        end
        if (wr_cfg && i_avs_writedata[attach_pkg::CFG_LOCAL_OFF_BIT]) begin
            nxt_ff.attach = attach_pkg::ST_OFFLINE;
        end
        if (go_online && sw_online && cur_ff.attach == attach_pkg::ST_OFFLINE) begin
            nxt_ff.attach = attach_pkg::ST_DISABLED;  // [R12]
            nxt_ff.remote_off = 1'b0;
        end
        if (nxt_ff.attach != attach_pkg::ST_OFFLINE && nxt_ff.transp && HAS_BACKPLANE) begin
            nxt_ff.attach = attach_pkg::ST_ENABLED;  // [R16]
        end else if (nxt_ff.attach == attach_pkg::ST_ENABLED) begin
            nxt_ff.attach = attach_pkg::ST_DISABLED;
        end
        if (gl_rst) begin
            nxt_ff.attach = attach_pkg::ST_DISABLED;  // [R3]
            nxt_ff.sreset_pend = 1'b0;
            nxt_ff.transp = 1'b0;
        end
        if (!sw_online) begin
            nxt_ff.attach = attach_pkg::ST_OFFLINE;  // [R10]
        end
        // Hot connection: lock, wait, switch relays, settle, release.
        unique case (cur_ff.lock)
            attach_pkg::LK_IDLE: begin
                nxt_ff.lock_cnt = '0;
                if ((nxt_ff.attach == attach_pkg::ST_OFFLINE) != cur_ff.relay_closed
                    || (wr_cfg && i_avs_writedata[attach_pkg::CFG_LOCK_REQ_BIT])) begin
                    nxt_ff.lock = attach_pkg::LK_PRE;  // [R18]
                end
            end
            attach_pkg::LK_PRE: begin
                nxt_ff.lock_cnt = cur_ff.lock_cnt + CNT_W_L'(1);
                if (lock_min_done) begin
                    nxt_ff.relay_closed = cur_ff.attach == attach_pkg::ST_OFFLINE;
                    nxt_ff.lock = attach_pkg::LK_SETTLE;
                    nxt_ff.lock_cnt = '0;
                end
            end
            attach_pkg::LK_SETTLE: begin
                nxt_ff.lock_cnt = cur_ff.lock_cnt + CNT_W_L'(1);
                if (cur_ff.lock_cnt >= CNT_W_L'(SETTLE_CYC)) begin
                    nxt_ff.lock = attach_pkg::LK_IDLE;  // [R19]
                end
            end
            default: nxt_ff.lock = attach_pkg::LK_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cur_ff <= '{attach: attach_pkg::POWERUP_STATE, lock: attach_pkg::LK_IDLE,
                sw_stable: 1'b1, sw_sync: 3'h7, default: '0};  // [R17]
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic online;
    logic enabled;
    assign online = (cur_ff.attach != attach_pkg::ST_OFFLINE) && !gl_rst;
    assign enabled = (cur_ff.attach == attach_pkg::ST_ENABLED) && !gl_rst;
    assign o_avs_readdata = cur_ff.rdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~cur_ff.rvalid;
    assign o_attach_state = cur_ff.attach;
    assign o_abort = gl_rst | !online;  // [R3] [R8]
    assign o_lines_release = gl_rst | !online | (cur_ff.sreset_pend & i_cycle_done);  // [R5]
    assign o_grant_out = online ? (i_grant_local & ~(i_lock_in | o_lock_out))
        : i_grant_in;  // [R9] [R20]
    assign o_lock_out = cur_ff.lock != attach_pkg::LK_IDLE;  // [R19] [R22]
    assign o_lock_oe = o_lock_out;
    assign o_relay_close = cur_ff.relay_closed;
    assign o_remove_ok = (cur_ff.attach == attach_pkg::ST_OFFLINE) && (cur_ff.lock ==
        attach_pkg::LK_IDLE);
    always_comb begin
        o_perm.slave_direct = online;  // [R13]
        o_perm.slave_transp = enabled;  // [R13]
        o_perm.master = online;  // [R15]
        o_perm.requester = online & ~(i_lock_in | o_lock_out);  // [R15] [R20]
        o_perm.intr_fwd = enabled;  // [R14]
        o_perm.iack_fwd = enabled;  // [R14]
        o_perm.intr_handler = online;  // [R15]
    end

endmodule // cable_bus_reset_and_attach_state

//--- cable_peer.sv
// Model of the other devices on the cable: global reset, grant chain, lock line.
// Assumes requests from the bench change just after a rising clock edge.
`timescale 1ns/1ps
module cable_peer #(
    parameter int HOLD_CYC = 40
) (
    input wire logic i_clk,
    input wire logic i_reset_req,
    input wire logic i_lock_req,
    input wire logic i_lock_out,
    input wire logic i_lock_oe,
    output logic o_cable_reset,
    output logic o_grant_in,
    output logic o_lock_in
);
    int hold_ff = 0;
    logic peer_lock_ff = 1'b0;
    initial o_grant_in = 1'b0;
    always @(posedge i_clk) begin
        o_grant_in <= ~o_grant_in;
        peer_lock_ff <= i_lock_req;
        if (i_reset_req)
            hold_ff <= HOLD_CYC;
        else if (hold_ff > 0)
            hold_ff <= hold_ff - 1;
    end
    // Global reset is held a whole shortened hold time once started.
    assign o_cable_reset = (hold_ff > 0);
    // The lock line is a wired OR of both parties.
    assign o_lock_in = (i_lock_oe & i_lock_out) | peer_lock_ff;
endmodule // cable_peer

//--- test_cable_bus_reset_and_attach_state.sv
// Self-checking bench for the attach controller with a cable peer model.
// Assumes the checker is bound to the controller from its own file.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: %h, expected %h", $time, (a), (b)); end end
module test_cable_bus_reset_and_attach_state;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic sw = 1'b1;
    logic glocal = 1'b1;
    logic done = 1'b0;
    logic rst_req = 1'b0;
    logic lock_req = 1'b0;
    logic [31:0] rdata, q;
    logic waitreq, grant_in, grant_out, lock_out, lock_oe, lock_in, relay, abort_w, release_w;
    logic cable_reset, remove_ok;
    logic [1:0] state;
    attach_pkg::perm_s perm;
    int n_errors = 0;
    int n_tests = 0;
    always #4 i_clk = ~i_clk;
    cable_bus_reset_and_attach_state #(.SETTLE_CYC(20), .DEBOUNCE_CYC(4)) i_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_cable_reset(cable_reset),
        .i_online_switch(sw), .i_grant_in(grant_in), .o_grant_out(grant_out),
        .i_grant_local(glocal), .i_cycle_done(done), .o_lock_out(lock_out), .o_lock_oe(lock_oe),
        .i_lock_in(lock_in), .o_relay_close(relay), .o_abort(abort_w),
        .o_lines_release(release_w), .o_remove_ok(remove_ok), .o_attach_state(state),
        .o_perm(perm));
    cable_peer #(.HOLD_CYC(40)) i_peer (.i_clk(i_clk), .i_reset_req(rst_req),
        .i_lock_req(lock_req), .i_lock_out(lock_out), .i_lock_oe(lock_oe),
        .o_cable_reset(cable_reset), .o_grant_in(grant_in), .o_lock_in(lock_in));
    task wrap_up;
        $display("mismatches %0d of %0d comparisons", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (waitreq !== 1'b0 && k < 20);
        `CHK(waitreq, 1'b0)
        if (waitreq !== 1'b0) wrap_up();
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task wait_st(input logic [1:0] s, input int n);
        int k;
        for (k = 0; k < n && state !== s; k++) @(posedge i_clk);
        `CHK(state, s)
        if (state !== s) wrap_up();
    endtask
    task lock_seq(input logic r);
        int h;
        for (h = 0; h < 400 && lock_oe !== 1'b1; h++) @(posedge i_clk);
        `CHK(lock_oe, 1'b1)
        if (lock_oe !== 1'b1) wrap_up();
        for (h = 0; h < 400 && relay !== r; h++) @(posedge i_clk);
        `CHK(relay, r)
        if (relay !== r) wrap_up();
        `CHK(h + 1 >= attach_pkg::RELAY_DELAY_CYC, 1'b1)
        for (h = 0; h < 400 && lock_oe === 1'b1; h++) @(posedge i_clk);
        `CHK(h >= 19 && h < 400, 1'b1)
        if (h >= 400) wrap_up();
    endtask
    task sres(input logic [3:0] a, input logic [31:0] d, input logic [1:0] s);
        logic seen;
        seen = 1'b0;
        bus(1'b1, attach_pkg::CSR_OFS, 32'hE);
        wait_st(2'b10, 4);
        bus(1'b1, a, d);
        repeat (3) @(posedge i_clk);
        `CHK(state, 2'b10)
        done <= 1'b1;
        repeat (4) begin
            @(posedge i_clk);
            done <= 1'b0;
            seen = seen | (release_w === 1'b1);
        end
        `CHK(state, s)
        `CHK(seen, s == 2'b01)
    endtask
    task t_remote;
        `CHK(grant_out, 1'b1)
        lock_req <= 1'b1;
        repeat (3) @(posedge i_clk);
        `CHK(grant_out, 1'b0)
        lock_req <= 1'b0;
        bus(1'b1, attach_pkg::CSR_OFS, 32'hE);
        `CHK(state, 2'b10)
        bus(1'b1, attach_pkg::CSR_OFS, 32'hC);
        wait_st(2'b00, 4);
        `CHK(grant_out, grant_in)
        lock_seq(1'b1);
        `CHK(remove_ok, 1'b1)
        bus(1'b1, attach_pkg::CSR_OFS, 32'hE);
        repeat (4) @(posedge i_clk);
        `CHK(state, 2'b00)
        bus(1'b1, attach_pkg::CFG_OFS, 32'h1);
        wait_st(2'b10, 4);
        lock_seq(1'b0);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        `CHK(state, 2'b01)
        `CHK(remove_ok, 1'b0)
        bus(1'b0, 4'h2, 32'h0);
        `CHK(q, attach_pkg::UNMAPPED_RD)
        bus(1'b0, attach_pkg::STAT_OFS, 32'h0);
        `CHK(q[1:0], 2'b01)
        bus(1'b1, attach_pkg::CSR_OFS, 32'hE);
        wait_st(2'b10, 4);
        t_remote();
        sres(attach_pkg::CSR_OFS, 32'hF, 2'b01);
        sres(attach_pkg::RR_OFS, 32'h4, 2'b10);
        sres(attach_pkg::RR_OFS, 32'h2, 2'b01);
        bus(1'b1, attach_pkg::CSR_OFS, 32'hE);
        rst_req <= 1'b1;
        @(posedge i_clk);
        rst_req <= 1'b0;
        wait_st(2'b01, 8);
        `CHK(abort_w, 1'b1)
        bus(1'b1, attach_pkg::CSR_OFS, 32'hE);
        `CHK(state, 2'b01)
        repeat (40) @(posedge i_clk);
        sw <= 1'b0;
        repeat (2) @(posedge i_clk);
        sw <= 1'b1;
        repeat (14) @(posedge i_clk);
        `CHK(state, 2'b01)
        sw <= 1'b0;
        wait_st(2'b00, 20);
        lock_seq(1'b1);
        bus(1'b1, attach_pkg::CFG_OFS, 32'h1);
        repeat (4) @(posedge i_clk);
        `CHK(state, 2'b00)
        wrap_up();
    end
endmodule // test_cable_bus_reset_and_attach_state
